// ---- wsfh_defs.vh ----
`ifndef WSFH_DEFS_VH
`define WSFH_DEFS_VH
// length of the completion pulse in clocks
`define WSFH_DONE_CLKS 2'h2
// one-hot states
`define WSFH_ST_IDLE 4'h1
`define WSFH_ST_REQ 4'h2
`define WSFH_ST_WAIT 4'h4
`define WSFH_ST_DONE 4'h8
// reset value of the shared line output
`define WSFH_LINE_IDLE 1'h1
`endif

// ---- wsfh_tag_tracker.v ----
`timescale 1ns/1ps
`include "wsfh_defs.vh"
// tracks buffer entries marked by a fence until each has drained
module wsfh_tag_tracker #(
  parameter DEPTH = 8
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire mark_i,
  input wire [DEPTH-1:0] occupied_i,
  input wire [DEPTH-1:0] coherent_i,
  output reg pending_o
);
  reg [DEPTH-1:0] tag_q;
  wire [DEPTH-1:0] tag_d;
  genvar g;
  // per entry: mark on fence if occupied, drop once coherent
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      assign tag_d[g] = mark_i ? occupied_i[g] & ~coherent_i[g]
                               : tag_q[g] & ~coherent_i[g];
    end
  endgenerate
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tag_q <= {DEPTH{1'b0}};
      pending_o <= 1'b0;
    end else begin
      tag_q <= tag_d; // R02
      pending_o <= |tag_d; // R02 R05
    end
  end
endmodule // wsfh_tag_tracker

// ---- wsfh_fence.v ----
`timescale 1ns/1ps
`include "wsfh_defs.vh"
// How it works
// R01: peripheral requests a fence with a one-clock low pulse on the line.
// R02: on request, tag all buffered write data and track it until coherent.
// R03: when tagged data is coherent, drive line low for two clocks.
// R04: line drive changes only on the rising clock edge; the async reset releases the line at once.
// R05: completion means all processor snoops for last write are finished.
// R06: peripheral sends interrupt message only after the completion pulse.
// R07: handshake used only when an interrupt controller is present.
// R08: line is three-stated while reset is asserted.
// R09: line idles high; no completion pulse without an outstanding request.
module wsfh_fence #(
  parameter DEPTH = 8
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire ioapic_en_i,
  input wire snoop_done_fence_line_i,
  output reg snoop_done_fence_line_o,
  output reg snoop_done_fence_line_oe_o,
  input wire [DEPTH-1:0] wbuf_occupied_i,
  input wire [DEPTH-1:0] wbuf_coherent_i,
  input wire snoops_busy_i,
  output reg fence_busy_o
);
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg mark;
  reg drive;
  wire pending;
  wire req_seen;

  // line sampled low while we are not driving is a request
  assign req_seen = ioapic_en_i & ~snoop_done_fence_line_i &
                    ~snoop_done_fence_line_oe_o; // R01 R07

  wsfh_tag_tracker #(.DEPTH(DEPTH)) u_trk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .mark_i(mark),
    .occupied_i(wbuf_occupied_i),
    .coherent_i(wbuf_coherent_i),
    .pending_o(pending)
  );

  // next state; tracker needs one clock to see the mark
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    mark = 1'b0;
    drive = 1'b0;
    case (state_q)
      `WSFH_ST_IDLE: begin
        if (req_seen) begin
          mark = 1'b1; // R02
          state_d = `WSFH_ST_REQ;
        end
      end
      `WSFH_ST_REQ: begin
        state_d = `WSFH_ST_WAIT;
      end
      `WSFH_ST_WAIT: begin
        // wait for drain and for snoops to settle
        if (!pending && !snoops_busy_i) begin // R02 R05
          drive = 1'b1; // R03 R09
          cnt_d = `WSFH_DONE_CLKS - 2'h1;
          state_d = `WSFH_ST_DONE;
        end
      end
      `WSFH_ST_DONE: begin
        if (cnt_q != 2'h0) begin
          drive = 1'b1; // R03
          cnt_d = cnt_q - 2'h1;
        end else begin
          state_d = `WSFH_ST_IDLE;
        end
      end
      default: begin
        state_d = `WSFH_ST_IDLE;
      end
    endcase
  end

  // all pin changes but the async reset registered on the rising edge
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= `WSFH_ST_IDLE;
      cnt_q <= 2'h0;
      snoop_done_fence_line_o <= `WSFH_LINE_IDLE;
      snoop_done_fence_line_oe_o <= 1'b0; // R08
      fence_busy_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      snoop_done_fence_line_o <= ~drive; // R04 R09
      snoop_done_fence_line_oe_o <= drive; // R04 R09
      fence_busy_o <= (state_d != `WSFH_ST_IDLE);
    end
  end
endmodule // wsfh_fence

// ---- wsfh_fence_props.sv ----
`timescale 1ns/1ps
module wsfh_chk(input wire clock_i,rst_n_i,ioapic_en_i,snoops_busy_i,
  input wire snoop_done_fence_line_i,snoop_done_fence_line_o,
  input wire snoop_done_fence_line_oe_o,fence_busy_o);
  wire oe=snoop_done_fence_line_oe_o,o=snoop_done_fence_line_o;
  wire b=fence_busy_o,l=snoop_done_fence_line_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // pulse rules, reset rule ignores the disable
  a_pulse_two_clk: assert property ($rose(oe) |=> oe ##1 !oe)
    else $error("pulse length");
  a_drive_low: assert property (oe |-> !o && b) else $error("drive");
  a_release_high: assert property (!oe |-> o) else $error("idle");
  a_req_taken: assert property (!l&&!oe&&ioapic_en_i&&!b |=> b)
    else $error("request lost");
  a_off_idle: assert property (!ioapic_en_i&&!b |=> !b) else $error("off");
  a_snoops_clear: assert property ($rose(oe) |-> !$past(snoops_busy_i))
    else $error("snoops busy");
  a_no_spurious: assert property ($rose(oe) |-> $past(b,2)) else $error("sp");
  a_reset_float: assert property (disable iff (1'b0) !rst_n_i |-> !oe)
    else $error("reset drive");
endmodule // wsfh_chk
bind wsfh_fence wsfh_chk chk(.*);

// ---- wsfh_peer.sv ----
`timescale 1ns/1ps
module wsfh_peer(input wire clock_i,fire_i,dev_oe_i,dev_o_i,
  output wire line_o,output reg msg_o);
  reg drv_q=0;
  reg [1:0] low_q=0;
  wire dev_low=dev_oe_i&&!dev_o_i;
  // pull-up: a released line reads high
  assign line_o=!(drv_q||dev_low);
  // message only once a full two-clock answer was seen
  always @(posedge clock_i) begin
    drv_q<=fire_i;
    low_q<=dev_low?low_q+2'h1:2'h0;
    msg_o<=low_q==2'h2&&!dev_low;
  end
endmodule // wsfh_peer

// ---- wsfh_fence_bench.sv ----
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if((a)!==(b)) begin mismatches++; \
  $display("[ERR] %0t %h %h",$time,a,b); end end
module wsfh_fence_bench;
  reg clock_i=0,rst_n_i=1,en=0,fire=0,sb=0;
  reg [7:0] occ=0,coh=0;
  reg [31:0] rs=32'h8d9438c0;
  wire line,oe,o,busy,msg;
  integer mismatches=0,checks_done=0,exp_msgs=0,got_msgs=0,i,k;
  integer oe_cyc=0;
  always #12.5 clock_i=~clock_i;
  wsfh_fence DUT(.clock_i(clock_i),.rst_n_i(rst_n_i),.ioapic_en_i(en),
    .snoop_done_fence_line_i(line),.snoop_done_fence_line_o(o),
    .snoop_done_fence_line_oe_o(oe),.wbuf_occupied_i(occ),
    .wbuf_coherent_i(coh),.snoops_busy_i(sb),.fence_busy_o(busy));
  wsfh_peer peer(.clock_i(clock_i),.fire_i(fire),.dev_oe_i(oe),
    .dev_o_i(o),.line_o(line),.msg_o(msg));
  // random buffer and snoop traffic so drains take varied time
  always @(posedge clock_i) begin
    rs^=rs<<13; rs^=rs>>17; rs^=rs<<5;
    #1 occ=rs[7:0]; coh=rs[15:8]; sb=rs[16]&rs[17];
  end
  always @(posedge clock_i) if(msg===1'b1) got_msgs++;
  // clocks the device spends driving the line
  always @(posedge clock_i) if(oe===1'b1) oe_cyc++;
  task print_verdict; begin
    $display("checks %0d mismatches %0d",checks_done,mismatches);
    if(mismatches==0&&checks_done>0) $display("bench passed");
    else $display("bench failed");
    $finish;
  end endtask
  initial begin
    #400000 mismatches++;
    print_verdict;
  end
  // one fence at a time, enable off about a quarter of the time
  initial begin
    // a real falling edge so the async reset fires at once
    #1 rst_n_i=0;
    repeat(5) @(posedge clock_i);
    #1 rst_n_i=1;
    for(i=0;i<40;i++) begin
      @(posedge clock_i) #1 en=rs[20]|rs[21]; fire=1;
      @(posedge clock_i) #1 fire=0;
      for(k=0;(busy!==1'b0||oe!==1'b0||k<3)&&k<300;k++) begin
        @(posedge clock_i);
        #1;
      end
      repeat(3) @(posedge clock_i);
      exp_msgs+=en;
      `CHK(k<300,1'b1)
      `CHK(got_msgs,exp_msgs)
      `CHK(oe_cyc,2*exp_msgs)
      `CHK(o,1'b1)
    end
    print_verdict;
  end
endmodule // wsfh_fence_bench
